// ==== rtl/adts_pkg.sv ====
// Purpose: Constants, register map and types for the conversion trigger sequencer.
// Assumes: 250 MHz system clock; registers are 32-bit words at byte offsets.
// Notes: Times are kept in microseconds and turned into clock counts here.
package adts_pkg;

	// Clock rate and documented times
	localparam real CLK_MHZ          = 250.0;
	localparam real T_DLY_PWM_MIN_US = 0.225;
	localparam real T_DLY_PWM_MAX_US = 0.3;
	localparam real T_DLY_TMR_MIN_US = 0.225;
	localparam real T_DLY_TMR_MAX_US = 0.5;
	localparam real T_DLY_SW_MIN_US  = 0.25;
	localparam real T_DLY_SW_MAX_US  = 0.525;
	localparam real T_CONV_US        = 1.85;
	localparam real T_GAP_MIN_US     = 0.175;
	localparam real T_GAP_PWM_MAX_US = 0.225;
	localparam real T_GAP_SW_MAX_US  = 0.425;

	// Cycle counts: least times rounded up
	localparam int DLY_PWM_CYC = int'($ceil(T_DLY_PWM_MIN_US * CLK_MHZ));
	localparam int DLY_TMR_CYC = int'($ceil(T_DLY_TMR_MIN_US * CLK_MHZ));
	localparam int DLY_SW_CYC  = int'($ceil(T_DLY_SW_MIN_US * CLK_MHZ));
	localparam int CONV_CYC    = int'($ceil(T_CONV_US * CLK_MHZ));
	localparam int GAP_CYC     = int'($ceil(T_GAP_MIN_US * CLK_MHZ));

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL      = 8'h00;
	localparam logic [7:0] OFS_STATUS    = 8'h04;
	localparam logic [7:0] OFS_SOFT_BASE = 8'h08;
	localparam logic [7:0] OFS_CONS_BASE = 8'h14;
	localparam logic [7:0] OFS_TMR_PROG  = 8'h20;
	localparam logic [7:0] OFS_PWM_BASE  = 8'h24;
	localparam logic [7:0] OFS_CMP0      = 8'h3C;
	localparam logic [7:0] OFS_CMP1      = 8'h40;
	localparam logic [7:0] OFS_RES_BASE  = 8'h44;

	// Control fields
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_CONST_BIT  = 1;
	localparam int CTRL_SWSTART_BIT = 2;

	// Slot byte fields
	localparam int         SLOT_EN_BIT = 7;
	localparam logic [7:0] SLOT_MASK   = 8'h9F;

	// Comparator control fields
	localparam int CMP_SEL_LSB = 0;
	localparam int CMP_DIR_BIT = 4;
	localparam int CMP_EN_BIT  = 7;
	localparam int CMP_VAL_LSB = 16;

	// Result register fields
	localparam int RES_OVR_BIT   = 30;
	localparam int RES_STORE_BIT = 31;

	// Result slots used by PWM and timer programs, and the no-slot marker
	localparam logic [3:0] RES_PWM_FIRST = 4'hC;
	localparam logic [3:0] RES_TIMER     = 4'hE;
	localparam logic [3:0] SLOT_NONE     = 4'hC;

	// Priority ranks
	localparam logic [2:0] RANK_TIMER = 3'h6;
	localparam logic [2:0] RANK_SOFT  = 3'h7;

	typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_CONV, ST_GAP} adts_state_t;
	typedef enum logic [1:0] {KIND_PWM, KIND_TIMER, KIND_SOFT, KIND_CONST} adts_kind_t;

endpackage

// ==== rtl/adts_sequencer.sv ====
// Purpose: Trigger arbitration, conversion sequencing, result store and monitoring.
// Assumes: Trigger inputs and bus signals are synchronous one-cycle pulses.
// Notes: The analog converter sees a start pulse and channel, returns data at the end.
`timescale 1ns/100ps
`default_nettype none
module adts_sequencer #(
	parameter int NUM_SLOTS = 12,
	parameter int NUM_PWM   = 6,
	parameter int NUM_RES   = 15,
	parameter int RES_W     = 12
) (
	// Clock and reset
	input  wire logic                 clock,
	input  wire logic                 reset,
	// Register port
	input  wire logic [7:0]           reg_addr,
	input  wire logic [31:0]          reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output logic      [31:0]          reg_rdata,
	// Trigger inputs
	input  wire logic [NUM_PWM-1:0]   pwm_trigger,
	input  wire logic                 timer_trigger,
	// Analog converter side
	output logic                      ana_start,
	output logic      [4:0]           ana_select,
	output logic                      ana_busy,
	input  wire logic [RES_W-1:0]     ana_result,
	// Interrupt pulses
	output logic                      compare_a_interrupt,
	output logic                      compare_b_interrupt,
	output logic                      pwm_program_done_interrupt,
	output logic                      software_program_done_interrupt
);
	import adts_pkg::*;

	localparam int CW = 10;

	// Configuration state
	logic                converter_enable_r;
	logic                const_enable_r;
	logic [7:0]          soft_slot_r  [NUM_SLOTS];
	logic [7:0]          const_slot_r [NUM_SLOTS];
	logic [7:0]          pwm_slot_r   [2*NUM_PWM];
	logic [7:0]          tmr_slot_r;
	logic [31:0]         cmp_ctrl_r   [2];
	// Pending requests
	logic [NUM_PWM-1:0]  pwm_pend_r;
	logic                tmr_pend_r;
	logic                soft_pend_r;
	// Running program
	adts_state_t         state_r;
	adts_kind_t          kind_r;
	logic [2:0]          pwm_idx_r;
	logic [2:0]          rank_r;
	logic [3:0]          slot_r;
	logic [CW-1:0]       cnt_r;
	// Results
	logic [RES_W-1:0]    res_data_r  [NUM_RES];
	logic [NUM_RES-1:0]  res_store_r;
	logic [NUM_RES-1:0]  res_ovr_r;
	// Output flops
	logic [31:0]         rdata_r;
	logic                ana_start_r;
	logic [4:0]          ana_select_r;
	logic                ana_busy_r;
	logic [1:0]          cmp_irq_r;
	logic                pwm_done_r;
	logic                soft_done_r;

	// Decoding shared by the bus writes and reads
	logic                wr_ctrl;
	logic                soft_start_wr;
	logic                res_hit;
	logic [3:0]          res_idx_rd;
	logic [NUM_RES-1:0]  res_clr;
	// Arbitration and sequencing
	logic                best_valid;
	logic [2:0]          best_rank;
	adts_kind_t          best_kind;
	logic [2:0]          best_pwm;
	logic [11:0]         best_en;
	logic [3:0]          best_first;
	logic                take;
	logic [11:0]         cur_en;
	logic [3:0]          next_slot;
	logic                store_ev;
	logic                prog_done;
	logic [3:0]          store_idx;
	logic [31:0]         rd_word;

	// First enabled slot at or above a position, SLOT_NONE if none
	function automatic logic [3:0] first_from(input logic [11:0] en, input logic [3:0] from);
		logic [3:0] r;
		r = SLOT_NONE;
		for (int i = 11; i >= 0; i--) begin
			if (en[i] && (4'(i) >= from)) begin
				r = 4'(i);
			end
		end
		return r;
	endfunction

	// Enable vector of a program's slots
	function automatic logic [11:0] prog_en(input adts_kind_t k, input logic [2:0] p);
		logic [11:0] e;
		e = 12'h000;
		for (int i = 0; i < NUM_SLOTS; i++) begin
			if (k == KIND_SOFT) begin
				e[i] = soft_slot_r[i][SLOT_EN_BIT];
			end else if (k == KIND_CONST) begin
				e[i] = const_slot_r[i][SLOT_EN_BIT];
			end
		end
		if (k == KIND_PWM) begin
			e[0] = pwm_slot_r[{p, 1'b0}][SLOT_EN_BIT];
			e[1] = pwm_slot_r[{p, 1'b1}][SLOT_EN_BIT];
		end else if (k == KIND_TIMER) begin
			e[0] = tmr_slot_r[SLOT_EN_BIT];
		end
		return e;
	endfunction

	// Analog input chosen by a slot
	function automatic logic [4:0] slot_sel(input adts_kind_t k, input logic [2:0] p,
		input logic [3:0] s);
		logic [7:0] b;
		unique case (k)
			KIND_PWM:   b = pwm_slot_r[{p, s[0]}];
			KIND_TIMER: b = tmr_slot_r;
			KIND_SOFT:  b = soft_slot_r[s];
			KIND_CONST: b = const_slot_r[s];
		endcase
		return b[4:0];
	endfunction

	// Start delay per trigger kind
	function automatic logic [CW-1:0] start_delay(input adts_kind_t k);
		unique case (k)
			KIND_PWM:   return CW'(DLY_PWM_CYC - 1);
			KIND_TIMER: return CW'(DLY_TMR_CYC - 1);
			default:    return CW'(DLY_SW_CYC - 1);
		endcase
	endfunction

	// Bus decode
	assign wr_ctrl       = reg_wr && (reg_addr == OFS_CTRL);
	assign soft_start_wr = wr_ctrl && reg_wdata[CTRL_SWSTART_BIT] && reg_wdata[CTRL_ENABLE_BIT];
	assign res_hit       = (reg_addr >= OFS_RES_BASE) &&
		(reg_addr < 8'(OFS_RES_BASE + 8'(4 * NUM_RES))) && (reg_addr[1:0] == 2'h0);
	assign res_idx_rd    = 4'((reg_addr - OFS_RES_BASE) >> 2);

	// Highest pending request
	always_comb begin
		best_valid = 1'b0;
		best_rank  = RANK_SOFT;
		best_kind  = KIND_CONST;
		best_pwm   = 3'h0;
		if (soft_pend_r || const_enable_r) begin
			best_valid = 1'b1;
			best_kind  = soft_pend_r ? KIND_SOFT : KIND_CONST;
		end
		if (tmr_pend_r) begin
			best_valid = 1'b1;
			best_rank  = RANK_TIMER;
			best_kind  = KIND_TIMER;
		end
		for (int i = NUM_PWM - 1; i >= 0; i--) begin
			if (pwm_pend_r[i]) begin
				best_valid = 1'b1;
				best_rank  = 3'(i);
				best_kind  = KIND_PWM;
				best_pwm   = 3'(i);
			end
		end
	end

	// Start or preempt; PWM never preempts PWM, equal ranks queue
	assign best_en    = prog_en(best_kind, best_pwm);
	assign best_first = first_from(best_en, 4'h0);
	assign take       = converter_enable_r && best_valid && ((state_r == ST_IDLE) ||
		((best_rank < rank_r) && (rank_r >= RANK_TIMER)));
	assign cur_en     = prog_en(kind_r, pwm_idx_r);
	assign next_slot  = first_from(cur_en, 4'(slot_r + 4'h1));
	assign store_ev   = converter_enable_r && !take && (state_r == ST_CONV) &&
		(cnt_r == '0);
	assign prog_done  = (store_ev && (next_slot == SLOT_NONE)) ||
		(take && (best_first == SLOT_NONE));

	// Result register of the converted slot
	always_comb begin
		unique case (kind_r)
			KIND_PWM:   store_idx = RES_PWM_FIRST + {3'h0, slot_r[0]};
			KIND_TIMER: store_idx = RES_TIMER;
			default:    store_idx = slot_r;
		endcase
	end

	// Configuration registers
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			converter_enable_r <= 1'b0;
			const_enable_r     <= 1'b0;
			tmr_slot_r         <= 8'h00;
			cmp_ctrl_r[0]      <= 32'h0000_0000;
			cmp_ctrl_r[1]      <= 32'h0000_0000;
			for (int i = 0; i < NUM_SLOTS; i++) begin
				soft_slot_r[i]  <= 8'h00;
				const_slot_r[i] <= 8'h00;
				pwm_slot_r[i]   <= 8'h00;
			end
		end else if (reg_wr) begin
			if (reg_addr == OFS_CTRL) begin
				converter_enable_r <= reg_wdata[CTRL_ENABLE_BIT];
				const_enable_r     <= reg_wdata[CTRL_CONST_BIT];
			end
			if (reg_addr == OFS_TMR_PROG) begin
				tmr_slot_r <= reg_wdata[7:0] & SLOT_MASK;
			end
			if (reg_addr == OFS_CMP0) begin
				cmp_ctrl_r[0] <= reg_wdata;
			end
			if (reg_addr == OFS_CMP1) begin
				cmp_ctrl_r[1] <= reg_wdata;
			end
			for (int i = 0; i < NUM_SLOTS; i++) begin
				if (reg_addr == 8'(OFS_SOFT_BASE + 8'(4 * (i / 4)))) begin
					soft_slot_r[i] <= reg_wdata[8*(i%4)+:8] & SLOT_MASK;
				end
				if (reg_addr == 8'(OFS_CONS_BASE + 8'(4 * (i / 4)))) begin
					const_slot_r[i] <= reg_wdata[8*(i%4)+:8] & SLOT_MASK;
				end
				if (reg_addr == 8'(OFS_PWM_BASE + 8'(4 * (i / 2)))) begin
					pwm_slot_r[i] <= reg_wdata[8*(i%2)+:8] & SLOT_MASK;
				end
			end
		end
	end

	// Pending requests; a new request in the clearing cycle wins
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			pwm_pend_r  <= '0;
			tmr_pend_r  <= 1'b0;
			soft_pend_r <= 1'b0;
		end else if (!converter_enable_r) begin
			pwm_pend_r  <= '0;
			tmr_pend_r  <= 1'b0;
			soft_pend_r <= soft_start_wr;
		end else begin
			for (int i = 0; i < NUM_PWM; i++) begin
				if (pwm_trigger[i]) begin
					pwm_pend_r[i] <= 1'b1;
				end else if (take && (best_kind == KIND_PWM) && (best_pwm == 3'(i))) begin
					pwm_pend_r[i] <= 1'b0;
				end
			end
			if (timer_trigger) begin
				tmr_pend_r <= 1'b1;
			end else if (prog_done && (kind_nxt_done() == KIND_TIMER)) begin
				tmr_pend_r <= 1'b0;
			end
			if (soft_start_wr) begin
				soft_pend_r <= 1'b1;
			end else if (prog_done && (kind_nxt_done() == KIND_SOFT)) begin
				soft_pend_r <= 1'b0;
			end
		end
	end

	// Kind of the program that completes in this cycle
	function automatic adts_kind_t kind_nxt_done();
		return take ? best_kind : kind_r;
	endfunction

	// Program sequencer
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			state_r      <= ST_IDLE;
			kind_r       <= KIND_CONST;
			pwm_idx_r    <= 3'h0;
			rank_r       <= RANK_SOFT;
			slot_r       <= 4'h0;
			cnt_r        <= '0;
			ana_start_r  <= 1'b0;
			ana_select_r <= 5'h00;
			ana_busy_r   <= 1'b0;
		end else begin
			ana_start_r <= 1'b0;
			if (!converter_enable_r) begin
				state_r    <= ST_IDLE;
				rank_r     <= RANK_SOFT;
				ana_busy_r <= 1'b0;
			end else if (take) begin
				kind_r    <= best_kind;
				pwm_idx_r <= best_pwm;
				rank_r    <= best_rank;
				slot_r    <= best_first;
				cnt_r     <= start_delay(best_kind);
				state_r   <= (best_first == SLOT_NONE) ? ST_IDLE : ST_DELAY;
				ana_busy_r <= 1'b0;
			end else begin
				unique case (state_r)
					ST_IDLE: begin
						rank_r <= RANK_SOFT;
					end
					ST_DELAY, ST_GAP: begin
						if (cnt_r == '0) begin
							state_r      <= ST_CONV;
							cnt_r        <= CW'(CONV_CYC - 1);
							ana_start_r  <= 1'b1;
							ana_select_r <= slot_sel(kind_r, pwm_idx_r, slot_r);
							ana_busy_r   <= 1'b1;
						end else begin
							cnt_r <= cnt_r - 1'b1;
						end
					end
					ST_CONV: begin
						if (cnt_r == '0) begin
							ana_busy_r <= 1'b0;
							slot_r     <= next_slot;
							if (next_slot == SLOT_NONE) begin
								state_r <= ST_IDLE;
								rank_r  <= RANK_SOFT;
							end else begin
								state_r <= ST_GAP;
								cnt_r   <= CW'(GAP_CYC - 1);
							end
						end else begin
							cnt_r <= cnt_r - 1'b1;
						end
					end
				endcase
			end
		end
	end

	// Result registers with stored and overrun flags
	genvar g;
	generate
		for (g = 0; g < NUM_RES; g++) begin : g_res
			assign res_clr[g] = reg_rd && res_hit && (res_idx_rd == 4'(g));
			always_ff @(posedge clock or posedge reset) begin
				if (reset) begin
					res_data_r[g]  <= '0;
					res_store_r[g] <= 1'b0;
					res_ovr_r[g]   <= 1'b0;
				end else if (store_ev && (store_idx == 4'(g))) begin
					res_data_r[g]  <= ana_result;
					res_store_r[g] <= 1'b1;
					res_ovr_r[g]   <= ~res_clr[g] & (res_ovr_r[g] | res_store_r[g]);
				end else if (res_clr[g]) begin
					res_store_r[g] <= 1'b0;
					res_ovr_r[g]   <= 1'b0;
				end
			end
		end
	endgenerate

	// Monitoring comparators, evaluated on the store itself
	generate
		for (g = 0; g < 2; g++) begin : g_cmp
			always_ff @(posedge clock or posedge reset) begin
				if (reset) begin
					cmp_irq_r[g] <= 1'b0;
				end else begin
					cmp_irq_r[g] <= store_ev && cmp_ctrl_r[g][CMP_EN_BIT] &&
						(store_idx == cmp_ctrl_r[g][CMP_SEL_LSB+:4]) &&
						(cmp_ctrl_r[g][CMP_DIR_BIT] ?
						(ana_result >= cmp_ctrl_r[g][CMP_VAL_LSB+:RES_W]) :
						(ana_result < cmp_ctrl_r[g][CMP_VAL_LSB+:RES_W]));
				end
			end
		end
	endgenerate

	// Program done interrupts
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			pwm_done_r  <= 1'b0;
			soft_done_r <= 1'b0;
		end else begin
			pwm_done_r  <= prog_done && (kind_nxt_done() == KIND_PWM);
			soft_done_r <= prog_done && (kind_nxt_done() == KIND_SOFT);
		end
	end

	// Read multiplexer
	always_comb begin
		rd_word = 32'h0000_0000;
		if (reg_addr == OFS_CTRL) begin
			rd_word[CTRL_ENABLE_BIT] = converter_enable_r;
			rd_word[CTRL_CONST_BIT]  = const_enable_r;
		end else if (reg_addr == OFS_STATUS) begin
			rd_word = {16'h0000, NUM_PWM'(pwm_pend_r), tmr_pend_r, soft_pend_r,
				slot_r, kind_r, state_r};
		end else if (reg_addr == OFS_TMR_PROG) begin
			rd_word[7:0] = tmr_slot_r;
		end else if (reg_addr == OFS_CMP0) begin
			rd_word = cmp_ctrl_r[0] & 32'h0FFF_009F;
		end else if (reg_addr == OFS_CMP1) begin
			rd_word = cmp_ctrl_r[1] & 32'h0FFF_009F;
		end else if (res_hit) begin
			rd_word[RES_W-1:0]    = res_data_r[res_idx_rd];
			rd_word[RES_OVR_BIT]   = res_ovr_r[res_idx_rd];
			rd_word[RES_STORE_BIT] = res_store_r[res_idx_rd];
		end
		for (int i = 0; i < NUM_SLOTS; i++) begin
			if (reg_addr == 8'(OFS_SOFT_BASE + 8'(4 * (i / 4)))) begin
				rd_word[8*(i%4)+:8] = soft_slot_r[i];
			end
			if (reg_addr == 8'(OFS_CONS_BASE + 8'(4 * (i / 4)))) begin
				rd_word[8*(i%4)+:8] = const_slot_r[i];
			end
			if (reg_addr == 8'(OFS_PWM_BASE + 8'(4 * (i / 2)))) begin
				rd_word[8*(i%2)+:8] = pwm_slot_r[i];
			end
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			rdata_r <= 32'h0000_0000;
		end else begin
			rdata_r <= reg_rd ? rd_word : 32'h0000_0000;
		end
	end

	// Outputs straight from flops
	assign reg_rdata                       = rdata_r;
	assign ana_start                       = ana_start_r;
	assign ana_select                      = ana_select_r;
	assign ana_busy                        = ana_busy_r;
	assign compare_a_interrupt             = cmp_irq_r[0];
	assign compare_b_interrupt             = cmp_irq_r[1];
	assign pwm_program_done_interrupt      = pwm_done_r;
	assign software_program_done_interrupt = soft_done_r;

endmodule
`default_nettype wire

// ==== testbench/adts_monitor.sv ====
// Purpose: Port-level checks of the trigger sequencer.
// Assumes: One clock domain; reset asynchronous, active high.
// Notes: Helper logic mirrors enable bits seen on the register port.
`timescale 1ns/100ps
`default_nettype none
module adts_monitor (
	// Clock and reset
	input wire logic        clock,
	input wire logic        reset,
	// Register port
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	// Converter and interrupts
	input wire logic        ana_start,
	input wire logic [4:0]  ana_select,
	input wire logic        ana_busy,
	input wire logic        compare_a_interrupt,
	input wire logic        pwm_program_done_interrupt
);
	import adts_pkg::*;
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);
	logic en_r;
	logic cmp0_en_r;
	int   busy_cnt_r;
	int   idle_cnt_r;
	// Enable bits as last written
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			en_r      <= 1'b0;
			cmp0_en_r <= 1'b0;
		end else if (reg_wr && reg_addr == OFS_CTRL) begin
			en_r <= reg_wdata[CTRL_ENABLE_BIT];
		end else if (reg_wr && reg_addr == OFS_CMP0) begin
			cmp0_en_r <= reg_wdata[CMP_EN_BIT];
		end
	end
	// Length of the current busy run and idle run
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			busy_cnt_r <= 0;
			idle_cnt_r <= 1000;
		end else if (ana_busy) begin
			busy_cnt_r <= busy_cnt_r + 1;
			idle_cnt_r <= 0;
		end else begin
			busy_cnt_r <= 0;
			idle_cnt_r <= (idle_cnt_r < 1000) ? idle_cnt_r + 1 : idle_cnt_r;
		end
	end
	// Conversion framing
	a_start_single: assert property (ana_start |=> !ana_start)
		else $error("start pulse longer than one cycle");
	a_busy_follows: assert property (ana_start |-> ##[0:1] ana_busy)
		else $error("busy missing after start");
	a_conv_length: assert property (busy_cnt_r <= CONV_CYC)
		else $error("conversion window too long");
	a_start_gap: assert property (ana_start |-> idle_cnt_r >= GAP_CYC)
		else $error("start too soon after previous conversion");
	a_start_enabled: assert property (ana_start |-> $past(en_r))
		else $error("start while converter disabled");
	a_select_steady: assert property (ana_busy && $past(ana_busy) |-> $stable(ana_select))
		else $error("input select moved during conversion");
	// Interrupt relations
	a_cmp_enabled: assert property (compare_a_interrupt |-> $past(cmp0_en_r))
		else $error("compare A while comparator off");
	a_cmp_at_store: assert property (compare_a_interrupt |->
		$past(ana_busy) || $past(ana_busy, 2) || $past(ana_busy, 3))
		else $error("compare A away from a result store");
	a_done_single: assert property (pwm_program_done_interrupt |=> !pwm_program_done_interrupt)
		else $error("program done pulse longer than one cycle");
endmodule
`default_nettype wire

// ==== testbench/adts_conv_model.sv ====
// Purpose: Behavioural analog converter facing the sequencer.
// Assumes: The sequencer samples data on the last busy cycle.
// Notes: Outside a conversion the data toggle so stale values never match.
`timescale 1ns/100ps
`default_nettype none
module adts_conv_model (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        reset,
	// Converter handshake
	input  wire logic        ana_start,
	input  wire logic [4:0]  ana_select,
	input  wire logic        ana_busy,
	output logic      [11:0] ana_result
);
	logic [4:0]  sel_r;
	logic [11:0] junk_r;
	// Latch input select at start, scramble idle data
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			sel_r  <= 5'h00;
			junk_r <= 12'h000;
		end else begin
			if (ana_start)
				sel_r <= ana_select;
			junk_r <= junk_r + 12'h5A3;
		end
	end
	// Data steady from the second busy cycle to the end of the conversion window
	assign ana_result = ana_busy ? {sel_r, 7'h2B} : junk_r;
endmodule
`default_nettype wire

// ==== testbench/adc_trigger_sequencer_tb.sv ====
// Purpose: Self-checking bench for the trigger sequencer.
// Assumes: Strobes change just after rising edges; converter is modelled.
// Notes: Covers delays, pending and preemption, restart, overrun and abort.
`timescale 1ns/100ps
`default_nettype none
module adc_trigger_sequencer_tb;
	import adts_pkg::*;
	logic        clock = 1'b0;
	logic        reset = 1'b1;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic [5:0]  pwm_trigger = 6'h00;
	logic        timer_trigger = 1'b0;
	logic        ana_start, ana_busy, cpa, cpb, pwd, swd;
	logic [4:0]  ana_select;
	logic [11:0] ana_result;
	int          fail_count = 0;
	int          check_count = 0;
	int          n_cpa = 0, n_cpb = 0, n_pwd = 0, n_swd = 0, n;
	logic [31:0] d;
	// Clock and interrupt pulse counts
	always #2 clock = ~clock;
	always @(posedge clock) begin
		n_cpa <= n_cpa + (cpa === 1'b1);
		n_cpb <= n_cpb + (cpb === 1'b1);
		n_pwd <= n_pwd + (pwd === 1'b1);
		n_swd <= n_swd + (swd === 1'b1);
	end
	adts_sequencer adts_sequencer_inst (.clock(clock), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.pwm_trigger(pwm_trigger), .timer_trigger(timer_trigger), .ana_start(ana_start),
		.ana_select(ana_select), .ana_busy(ana_busy), .ana_result(ana_result),
		.compare_a_interrupt(cpa), .compare_b_interrupt(cpb),
		.pwm_program_done_interrupt(pwd), .software_program_done_interrupt(swd));
	adts_conv_model adts_conv_model_inst (.clock(clock), .reset(reset), .ana_start(ana_start),
		.ana_select(ana_select), .ana_busy(ana_busy), .ana_result(ana_result));
	task automatic results;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clock);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= v;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clock);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	task automatic trig(input int k);
		@(posedge clock);
		pwm_trigger <= 6'(1 << k);
		@(posedge clock);
		pwm_trigger <= 6'h00;
	endtask
	// Counts edges up to the next start pulse, bounded
	task automatic wait_start(output int cyc);
		cyc = 0;
		do begin
			@(posedge clock);
			#1 cyc++;
		end while (ana_start !== 1'b1 && cyc < 3000);
		if (cyc >= 3000) begin
			fail_count++;
			results();
		end
	endtask
	task automatic t_regs;
		rd(OFS_CTRL, d);
		chk(d, 32'h0);
		wr(8'hFC, 32'hFFFF_FFFF);
		rd(8'hFC, d);
		chk(d, 32'h0);
		wr(OFS_CMP0, 32'h0000_0090);
		rd(OFS_CMP0, d);
		chk(d, 32'h0000_0090);
		$display("test regs done");
	endtask
	task automatic t_pwm;
		wr(OFS_CTRL, 32'h1);
		wr(OFS_PWM_BASE, 32'h0000_8A89);
		wr(OFS_PWM_BASE + 8'h08, 32'h0000_008C);
		trig(0);
		wait_start(n);
		chk(n >= 55 && n <= 76, 1'b1);
		chk(ana_select, 5'h09);
		trig(2);
		wait_start(n);
		chk(n >= CONV_CYC + GAP_CYC - 3 && n <= CONV_CYC + 56, 1'b1);
		chk(ana_select, 5'h0A);
		wait_start(n);
		chk(ana_select, 5'h0C);
		repeat (CONV_CYC + 4) @(posedge clock);
		chk(n_pwd, 2);
		rd(OFS_RES_BASE + 8'h34, d);
		chk(d[11:0], {5'h0A, 7'h2B});
		$display("test pwm done");
	endtask
	task automatic t_timer;
		wr(OFS_TMR_PROG, 32'h0000_008C);
		@(posedge clock);
		timer_trigger <= 1'b1;
		@(posedge clock);
		timer_trigger <= 1'b0;
		wait_start(n);
		chk(n >= DLY_TMR_CYC && n <= T_DLY_TMR_MAX_US * CLK_MHZ, 1'b1);
		chk(ana_select, 5'h0C);
		repeat (CONV_CYC + 4) @(posedge clock);
		rd(OFS_RES_BASE + 8'h38, d);
		chk(d, {1'b1, 19'h0, 5'h0C, 7'h2B});
		$display("test timer done");
	endtask
	task automatic t_preempt;
		wr(OFS_SOFT_BASE, 32'h0000_8A89);
		wr(OFS_PWM_BASE + 8'h04, 32'h0000_008B);
		wr(OFS_CTRL, 32'h5);
		wait_start(n);
		chk(ana_select, 5'h09);
		repeat (100) @(posedge clock);
		trig(1);
		wait_start(n);
		chk(n <= 76, 1'b1);
		chk(ana_select, 5'h0B);
		wait_start(n);
		chk(ana_select, 5'h09);
		chk(n_swd, 0);
		wait_start(n);
		chk(ana_select, 5'h0A);
		repeat (CONV_CYC + 4) @(posedge clock);
		chk(n_swd, 1);
		rd(OFS_RES_BASE, d);
		chk(d, {1'b1, 19'h0, 5'h09, 7'h2B});
		$display("test preempt done");
	endtask
	task automatic t_const;
		wr(OFS_CTRL, 32'h0);
		rd(OFS_RES_BASE, d);
		wr(OFS_CMP1, 32'h0000_0010);
		wr(OFS_CONS_BASE, 32'h0000_0089);
		wr(OFS_CTRL, 32'h3);
		repeat (3) wait_start(n);
		rd(OFS_RES_BASE, d);
		chk(d, {2'b11, 18'h0, 5'h09, 7'h2B});
		rd(OFS_RES_BASE, d);
		chk(d[30], 1'b0);
		chk(n_cpa, 3);
		chk(n_cpb, 0);
		wr(OFS_CMP1, 32'h04AC_0080);
		wait_start(n);
		chk(n_cpb, 1);
		wr(OFS_CTRL, 32'h0);
		$display("test constant done");
	endtask
	task automatic t_abort;
		rd(OFS_RES_BASE, d);
		wr(OFS_CTRL, 32'h5);
		wait_start(n);
		repeat (50) @(posedge clock);
		wr(OFS_CTRL, 32'h0);
		@(posedge clock);
		#1 chk(ana_busy, 1'b0);
		repeat (CONV_CYC + 20) @(posedge clock);
		rd(OFS_RES_BASE, d);
		chk(d[31:30], 2'b00);
		$display("test abort done");
	endtask
	// Main sequence
	initial begin
		repeat (3) @(posedge clock);
		reset <= 1'b0;
		t_regs();
		t_pwm();
		t_timer();
		t_preempt();
		t_const();
		t_abort();
		results();
	end
endmodule
bind adts_sequencer adts_monitor adts_monitor_inst (.clock(clock), .reset(reset),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .ana_start(ana_start),
	.ana_select(ana_select), .ana_busy(ana_busy), .compare_a_interrupt(compare_a_interrupt),
	.pwm_program_done_interrupt(pwm_program_done_interrupt));
`default_nettype wire
